// ### design/sembus_pkg.sv
// package for the stretchable external memory bus unit
package sembus_pkg;
  // ==========================================================
  // special function space map
  localparam logic [7:0] CLOCK_CONTROL_ADDR = 8'h8e;
  localparam logic [7:0] POINTER_SELECT_ADDR = 8'h86;
  localparam logic [7:0] DPTR0_LO_ADDR = 8'h82;
  localparam logic [7:0] DPTR0_HI_ADDR = 8'h83;
  localparam logic [7:0] DPTR1_LO_ADDR = 8'h84;
  localparam logic [7:0] DPTR1_HI_ADDR = 8'h85;
  // ==========================================================
  // field layout and reset values
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_W = 3;
  localparam int TIMER_MODE_LSB = 3;
  localparam int TIMER_MODE_W = 3;
  localparam int SELECT_BIT = 0;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [2:0] TIMER_MODE_RESET = 3'h0;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MACHINE_CYCLE_CLKS = 4;
  localparam logic [1:0] LAST_PHASE = 2'h3;
  localparam int BASE_DATA_CYCLES = 2;
  localparam int STROBE_CLKS_ZERO = 2;
  localparam int SCRATCH_BYTES = 256;
  // ==========================================================
  // types
  typedef enum logic [1:0] {SEMBUS_FETCH, SEMBUS_DATA} sembus_state_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sembus_sfr_req_t;
  typedef struct packed {
    logic ale;
    logic psen_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] upper_addr;
    logic [7:0] low_out;
    logic low_oe;
  } sembus_pins_t;
endpackage

// ### design/sembus_top.sv
// external memory bus unit with stretchable data transfers
//==========================================================
// What this block does
// R1: stretch setting lives in bits 2..0 of clock control at 8eh.
// R2: stretch accepts values 0 to 7, each a different data transfer length.
// R3: data transfer lasts stretch plus two machine cycles.
// R4: stretch resets to one, giving three-cycle data transfers.
// R5: nonzero stretch widens the read or write strobe and its timing.
// R6: program fetch timing never depends on the stretch value.
// R7: program fetch runs at fixed four-clock machine cycles.
// R8: low address muxed with data on low bus, high address on upper port.
// R9: no internal program memory; 256 bytes scratchpad only.
// R10: software may rewrite stretch anytime; next transfers use it.
// R11: exactly one address latch pulse per four-clock machine cycle.
// R12: write strobe driven on its own pin during data writes.
// R13: select bit at lsb of 86h picks one of two data pointers.
// R14: strobe lasts two clocks at stretch 0, else four per stretch unit.
`timescale 1ns/1ps
module sembus_top (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire sembus_pkg::sembus_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [15:0] fetch_addr_i,
  input wire logic data_req_i,
  input wire logic data_write_i,
  input wire logic [7:0] data_wdata_i,
  output logic data_done_o,
  output logic [7:0] data_rdata_o,
  output logic [7:0] fetch_data_o,
  output logic fetch_valid_o,
  input wire logic [7:0] low_bus_port_i,
  output logic [7:0] low_bus_port_o,
  output logic low_bus_port_oe_o,
  output logic [7:0] upper_address_port_o,
  output logic ale_o,
  output logic psen_n_o,
  output logic rd_n_o,
  output logic wr_n_o
);
  import sembus_pkg::*;
  // ==========================================================
  // reset release
  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  // ==========================================================
  // special function registers
  logic [2:0] stretch_reg, stretch_next;
  logic [2:0] timer_mode_reg, timer_mode_next;
  logic select_reg, select_next;
  logic [15:0] dptr0_reg, dptr0_next, dptr1_reg, dptr1_next;
  logic [7:0] sfr_rdata_reg, sfr_rdata_next;
  logic [15:0] data_addr;
  always_comb begin
    stretch_next = stretch_reg;
    timer_mode_next = timer_mode_reg;
    select_next = select_reg;
    dptr0_next = dptr0_reg;
    dptr1_next = dptr1_reg;
    if (sfr_req_i.valid && sfr_req_i.write) begin
      case (sfr_req_i.addr)
        CLOCK_CONTROL_ADDR: begin
          stretch_next = sfr_req_i.wdata[STRETCH_LSB +: STRETCH_W]; // see R1 see R2 see R10
          timer_mode_next = sfr_req_i.wdata[TIMER_MODE_LSB +: TIMER_MODE_W];
        end
        POINTER_SELECT_ADDR: select_next = sfr_req_i.wdata[SELECT_BIT]; // see R13
        DPTR0_LO_ADDR: dptr0_next[7:0] = sfr_req_i.wdata;
        DPTR0_HI_ADDR: dptr0_next[15:8] = sfr_req_i.wdata;
        DPTR1_LO_ADDR: dptr1_next[7:0] = sfr_req_i.wdata;
        DPTR1_HI_ADDR: dptr1_next[15:8] = sfr_req_i.wdata;
        default: ;
      endcase
    end
    case (sfr_req_i.addr)
      CLOCK_CONTROL_ADDR: sfr_rdata_next = {2'h0, timer_mode_reg, stretch_reg};
      POINTER_SELECT_ADDR: sfr_rdata_next = {7'h00, select_reg}; // upper bits read zero
      DPTR0_LO_ADDR: sfr_rdata_next = dptr0_reg[7:0];
      DPTR0_HI_ADDR: sfr_rdata_next = dptr0_reg[15:8];
      DPTR1_LO_ADDR: sfr_rdata_next = dptr1_reg[7:0];
      DPTR1_HI_ADDR: sfr_rdata_next = dptr1_reg[15:8];
      default: sfr_rdata_next = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      stretch_reg <= STRETCH_RESET; // see R4
      timer_mode_reg <= TIMER_MODE_RESET;
      select_reg <= 1'b0;
      dptr0_reg <= 16'h0000;
      dptr1_reg <= 16'h0000;
      sfr_rdata_reg <= 8'h00;
    end else begin
      stretch_reg <= stretch_next;
      timer_mode_reg <= timer_mode_next;
      select_reg <= select_next;
      dptr0_reg <= dptr0_next;
      dptr1_reg <= dptr1_next;
      sfr_rdata_reg <= sfr_rdata_next;
    end
  end
  assign data_addr = select_reg ? dptr1_reg : dptr0_reg; // see R13
  // ==========================================================
  // bus sequencer
  // phase counts the four clocks of every machine cycle; it never stops, so ale
  // stays one pulse per machine cycle whatever the transfer length.
  sembus_state_t state_reg, state_next;
  logic [1:0] phase_reg, phase_next;
  logic [3:0] mc_reg, mc_next;
  logic [4:0] strobe_reg, strobe_next;
  logic [2:0] cur_stretch_reg, cur_stretch_next;
  logic cur_write_reg, cur_write_next;
  logic [7:0] wdata_reg, wdata_next;
  logic pend_reg, pend_next, pend_wr_reg, pend_wr_next;
  logic [7:0] pend_wdata_reg, pend_wdata_next;
  logic done_next, fvalid_next;
  logic [7:0] drdata_next, fdata_next;
  sembus_pins_t pins_reg, pins_next;
  logic [3:0] total_mc;
  logic [4:0] strobe_len;
  always_comb begin
    phase_next = phase_reg + 2'h1; // see R7
    state_next = state_reg;
    mc_next = mc_reg;
    strobe_next = strobe_reg;
    cur_stretch_next = cur_stretch_reg;
    cur_write_next = cur_write_reg;
    wdata_next = wdata_reg;
    pend_next = pend_reg | data_req_i;
    pend_wr_next = data_req_i ? data_write_i : pend_wr_reg;
    pend_wdata_next = data_req_i ? data_wdata_i : pend_wdata_reg;
    done_next = 1'b0;
    fvalid_next = 1'b0;
    drdata_next = data_rdata_o;
    fdata_next = fetch_data_o;
    pins_next = pins_reg;
    total_mc = 4'(cur_stretch_reg) + 4'(BASE_DATA_CYCLES); // see R3
    strobe_len = (cur_stretch_reg == 3'h0) ? 5'(STROBE_CLKS_ZERO)
                 : 5'({cur_stretch_reg, 2'h0}); // see R5 see R14
    // ale rides in the second clock, where the address stands on the low bus, so a latch catches it
    pins_next.ale = (phase_next == 2'h1); // see R11
    if (strobe_reg != 5'h00) begin
      strobe_next = strobe_reg - 5'h01;
    end
    case (state_reg)
      SEMBUS_FETCH: begin
        // fetch fixed at one machine cycle; stretch only latched here for the next data transfer (see R6 see R9)
        pins_next.upper_addr = fetch_addr_i[15:8]; // see R8
        pins_next.rd_n = 1'b1;
        pins_next.wr_n = 1'b1;
        case (phase_reg)
          2'h0: begin
            pins_next.low_out = fetch_addr_i[7:0]; // see R8
            pins_next.low_oe = 1'b1;
            pins_next.psen_n = 1'b1;
          end
          2'h1: begin
            pins_next.low_oe = 1'b0;
            pins_next.psen_n = 1'b0;
          end
          2'h2: pins_next.psen_n = 1'b0;
          default: begin
            pins_next.psen_n = 1'b1;
            fdata_next = low_bus_port_i;
            fvalid_next = 1'b1;
          end
        endcase
        if (phase_reg == LAST_PHASE && pend_reg) begin
          state_next = SEMBUS_DATA;
          cur_stretch_next = stretch_reg; // see R10
          cur_write_next = pend_wr_reg;
          wdata_next = pend_wdata_reg;
          pend_next = data_req_i;
          mc_next = 4'h0;
          pins_next.upper_addr = data_addr[15:8];
          pins_next.low_out = data_addr[7:0];
          pins_next.low_oe = 1'b1;
        end
      end
      SEMBUS_DATA: begin
        pins_next.psen_n = 1'b1;
        if (phase_reg == LAST_PHASE) begin
          mc_next = mc_reg + 4'h1;
        end
        if (mc_reg == 4'h0 && phase_reg == 2'h1) begin
          // strobe starts after the address phase of the first machine cycle
          strobe_next = strobe_len;
          pins_next.low_out = wdata_reg;
          pins_next.low_oe = cur_write_reg;
        end
        pins_next.rd_n = !(strobe_next != 5'h00 && !cur_write_reg);
        pins_next.wr_n = !(strobe_next != 5'h00 && cur_write_reg); // see R12
        if (strobe_reg == 5'h01 && !cur_write_reg) begin
          drdata_next = low_bus_port_i;
        end
        if (phase_reg == LAST_PHASE && mc_reg == total_mc - 4'h1) begin
          state_next = SEMBUS_FETCH;
          done_next = 1'b1;
          pins_next.low_oe = 1'b0;
        end
      end
      default: state_next = SEMBUS_FETCH;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SEMBUS_FETCH;
      phase_reg <= 2'h0;
      mc_reg <= 4'h0;
      strobe_reg <= 5'h00;
      cur_stretch_reg <= STRETCH_RESET;
      cur_write_reg <= 1'b0;
      wdata_reg <= 8'h00;
      pend_reg <= 1'b0;
      pend_wr_reg <= 1'b0;
      pend_wdata_reg <= 8'h00;
      pins_reg <= '{ale: 1'b0, psen_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                    upper_addr: 8'h00, low_out: 8'h00, low_oe: 1'b0};
      data_done_o <= 1'b0;
      data_rdata_o <= 8'h00;
      fetch_data_o <= 8'h00;
      fetch_valid_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      mc_reg <= mc_next;
      strobe_reg <= strobe_next;
      cur_stretch_reg <= cur_stretch_next;
      cur_write_reg <= cur_write_next;
      wdata_reg <= wdata_next;
      pend_reg <= pend_next;
      pend_wr_reg <= pend_wr_next;
      pend_wdata_reg <= pend_wdata_next;
      pins_reg <= pins_next;
      data_done_o <= done_next;
      data_rdata_o <= drdata_next;
      fetch_data_o <= fdata_next;
      fetch_valid_o <= fvalid_next;
    end
  end
  assign sfr_rdata_o = sfr_rdata_reg;
  assign low_bus_port_o = pins_reg.low_out;
  assign low_bus_port_oe_o = pins_reg.low_oe;
  assign upper_address_port_o = pins_reg.upper_addr;
  assign ale_o = pins_reg.ale;
  assign psen_n_o = pins_reg.psen_n;
  assign rd_n_o = pins_reg.rd_n;
  assign wr_n_o = pins_reg.wr_n;
endmodule // sembus_top

// ### verification/sembus_top_chk.sv
// assertion checker for the external memory bus unit
`timescale 1ns/1ps
module sembus_top_chk (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire sembus_pkg::sembus_sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic data_done_o,
  input wire logic fetch_valid_o,
  input wire logic low_bus_port_oe_o,
  input wire logic ale_o,
  input wire logic psen_n_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o
);
  import sembus_pkg::*;
  // ====
  // shadow stretch and strobe length; a stretch write mid-transfer is not modelled
  logic [2:0] stretch_reg;
  logic [4:0] low_cnt_reg;
  wire strobe_on = !rd_n_o || !wr_n_o;
  wire [4:0] exp_w = (stretch_reg == 3'h0) ? 5'h2 : {stretch_reg, 2'h0};
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stretch_reg <= 3'h1;
      low_cnt_reg <= 5'h0;
    end else begin
      if (sfr_req_i.valid && sfr_req_i.write && sfr_req_i.addr == CLOCK_CONTROL_ADDR) begin
        stretch_reg <= sfr_req_i.wdata[2:0];
      end
      low_cnt_reg <= strobe_on ? low_cnt_reg + 5'h1 : 5'h0;
    end
  end
  // ====
  // properties
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_ale_gap;
    !ale_o [*3];
  endsequence
  a_ale_once: assert property (ale_o |=> s_ale_gap ##1 ale_o) else $error("ale spacing");
  a_psen_width: assert property ($fell(psen_n_o) |=> !psen_n_o ##1 psen_n_o) else $error("psen width");
  a_fetch_spacing: assert property (fetch_valid_o |=> !fetch_valid_o [*3]) else $error("fetch rate");
  a_strobe_width: assert property (!strobe_on && low_cnt_reg != 5'h0 |-> low_cnt_reg == exp_w)
    else $error("strobe width");
  a_strobe_apart: assert property (!(strobe_on && !psen_n_o) && (rd_n_o || wr_n_o)) else $error("strobe overlap");
  a_write_drives: assert property (!wr_n_o |-> low_bus_port_oe_o) else $error("write not driven");
  a_read_floats: assert property (!rd_n_o |-> !low_bus_port_oe_o) else $error("read driven");
  a_done_follows: assert property ($rose(rd_n_o) || $rose(wr_n_o) |-> ##[0:8] data_done_o)
    else $error("done late");
  a_sel_upper_zero: assert property ($past(sfr_req_i.addr) == POINTER_SELECT_ADDR |-> sfr_rdata_o[7:1] == 7'h0)
    else $error("select upper bits");
  a_stretch_read: assert property ($past(sfr_req_i.addr) == CLOCK_CONTROL_ADDR && !$past(sfr_req_i.valid)
    |-> sfr_rdata_o[2:0] == stretch_reg) else $error("stretch readback");
endmodule // sembus_top_chk

// ### verification/sembus_xmem.sv
// external memory model on the multiplexed bus
`timescale 1ns/1ps
module sembus_xmem (
  input wire logic clk_sys_i,
  input wire logic [7:0] bus_i,
  input wire logic [7:0] upper_i,
  input wire logic ale_i,
  input wire logic psen_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [4:0] lat_i,
  output logic [7:0] drive_o
);
  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  logic [4:0] wait_reg;
  logic [7:0] mem [0:255];
  always_ff @(posedge clk_sys_i) begin
    // ale keeps pulsing inside stretched transfers; only latch while the strobes are idle
    if (ale_i && rd_n_i && wr_n_i) begin
      lo_reg <= bus_i;
      hi_reg <= upper_i;
    end
    wait_reg <= rd_n_i ? 5'h0 : wait_reg + 5'h1;
    if (!wr_n_i) mem[lo_reg ^ hi_reg] <= bus_i;
    // slow memory: data only after lat_i strobe clocks
    if (!psen_n_i) drive_o <= lo_reg ^ hi_reg ^ 8'h5a;
    else if (!rd_n_i && wait_reg >= lat_i) drive_o <= mem[lo_reg ^ hi_reg];
    else drive_o <= ~drive_o;
  end
endmodule // sembus_xmem

// ### verification/sembus_top_bench.sv
// testbench for the external memory bus unit
`timescale 1ns/1ps
module sembus_top_bench;
  import sembus_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  sembus_sfr_req_t sfr_req_i = '0;
  logic [15:0] fetch_addr_i = 16'h1234;
  logic data_req_i = 1'b0;
  logic data_write_i = 1'b0;
  logic [7:0] data_wdata_i = 8'h00;
  logic [4:0] lat = 5'h0;
  logic [7:0] sfr_rdata_o, data_rdata_o, fetch_data_o, low_bus_port_o, upper_address_port_o, drive;
  logic data_done_o, fetch_valid_o, low_bus_port_oe_o, ale_o, psen_n_o, rd_n_o, wr_n_o;
  wire [7:0] bus = low_bus_port_oe_o ? low_bus_port_o : drive;
  int n_errors = 0;
  int num_checks = 0;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  sembus_top u_sembus_top(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o), .fetch_addr_i(fetch_addr_i), .data_req_i(data_req_i),
    .data_write_i(data_write_i), .data_wdata_i(data_wdata_i), .data_done_o(data_done_o),
    .data_rdata_o(data_rdata_o), .fetch_data_o(fetch_data_o), .fetch_valid_o(fetch_valid_o),
    .low_bus_port_i(bus), .low_bus_port_o(low_bus_port_o), .low_bus_port_oe_o(low_bus_port_oe_o),
    .upper_address_port_o(upper_address_port_o), .ale_o(ale_o), .psen_n_o(psen_n_o),
    .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
  sembus_xmem u_sembus_xmem(.clk_sys_i(clk_sys_i), .bus_i(bus), .upper_i(upper_address_port_o),
    .ale_i(ale_o), .psen_n_i(psen_n_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .lat_i(lat), .drive_o(drive));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task tick;
    @(posedge clk_sys_i);
    #1;
  endtask
  task sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req_i = '{1'b1, 1'b1, a, d};
    tick;
    sfr_req_i.valid = 1'b0;
    tick;
  endtask
  task sfr_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_req_i = '{1'b0, 1'b0, a, 8'h00};
    tick;
    tick;
    d = sfr_rdata_o;
  endtask
  // counts strobe-low clocks and clocks from request to done
  task xfer(input logic wr, input logic [7:0] d, output logic [7:0] w, output int n, output logic [7:0] q);
    data_req_i = 1'b1;
    data_write_i = wr;
    data_wdata_i = d;
    tick;
    data_req_i = 1'b0;
    w = 8'h00;
    n = 1;
    while (data_done_o !== 1'b1 && n < 200) begin
      if (rd_n_o === 1'b0 || wr_n_o === 1'b0) w++;
      tick;
      n++;
    end
    if (n == 200) begin
      n_errors++;
      report_and_stop;
    end
    q = data_rdata_o;
  endtask
  initial begin : main
    logic [7:0] v, w, q;
    int dur, s;
    repeat (8) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    repeat (3) tick;
    sfr_rd(CLOCK_CONTROL_ADDR, v);
    check(v, 8'h01);
    sfr_rd(POINTER_SELECT_ADDR, v);
    check(v, 8'h00);
    sfr_wr(DPTR0_LO_ADDR, 8'h10);
    sfr_wr(DPTR0_HI_ADDR, 8'h12);
    sfr_wr(DPTR1_LO_ADDR, 8'h20);
    sfr_wr(DPTR1_HI_ADDR, 8'h00);
    for (s = 0; s < 8; s++) begin
      sfr_wr(CLOCK_CONTROL_ADDR, 8'(s));
      sfr_rd(CLOCK_CONTROL_ADDR, v);
      check(v, 8'(s));
      sfr_wr(POINTER_SELECT_ADDR, {7'h0, s[0]});
      lat = 5'(2 * s);
      xfer(1'b1, 8'ha0 + 8'(s), w, dur, q);
      check(w, (s == 0) ? 8'h02 : 8'(4 * s));
      check(8'(dur >= (s + 2) * 4 + 2 && dur <= (s + 2) * 4 + 5), 8'h01);
      xfer(1'b0, 8'h00, w, dur, q);
      check(q, 8'ha0 + 8'(s));
      check(w, (s == 0) ? 8'h02 : 8'(4 * s));
    end
    sfr_wr(POINTER_SELECT_ADDR, 8'h00);
    xfer(1'b0, 8'h00, w, dur, q);
    check(q, 8'ha6);
    dur = 0;
    while (fetch_valid_o !== 1'b1 && dur < 40) begin
      tick;
      dur++;
    end
    if (dur == 40) begin
      n_errors++;
    end
    check(fetch_data_o, 8'h12 ^ 8'h34 ^ 8'h5a);
    report_and_stop;
  end
endmodule // sembus_top_bench
bind sembus_top sembus_top_chk u_sembus_top_chk(.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .data_done_o(data_done_o), .fetch_valid_o(fetch_valid_o),
  .low_bus_port_oe_o(low_bus_port_oe_o), .ale_o(ale_o), .psen_n_o(psen_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o));
